/* File: rtl/psl_pkg.sv */
/*
 * Shared constants and types for the power status and LED indicator block.
 * Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
 */
package psl_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int BLINK_PERIOD_MS = 1000;
   localparam int DUTY_SLOTS = 10;
   localparam logic [3:0] LAST_SLOT = 4'h9;

   // ****************************************************************
   // Register map (byte addresses) and fields
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_HOST_SD = 0;
   localparam int CTRL_MOMENTARY = 1;
   localparam int CTRL_ACT_LOW = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // LED colour words, laid out 00.RR.GG.BB, 0x00..0x3F per colour
   // ****************************************************************
   typedef logic [31:0] psl_rgb_t;
   localparam psl_rgb_t RGB_OFF = 32'h0000_0000;
   localparam psl_rgb_t RGB_RED = 32'h001F_0000;
   localparam psl_rgb_t RGB_GREEN = 32'h0000_0F00;
   localparam psl_rgb_t RGB_BLUE = 32'h0000_000F;
   localparam psl_rgb_t RGB_YELLOW = 32'h000C_0500;
   localparam psl_rgb_t RGB_ORANGE = 32'h0018_0200;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_OFF,
      ST_STARTUP,
      ST_ON,
      ST_SHUTDOWN
   } psl_state_e;

   // Conditions reported by the board monitors, synchronised as a group
   typedef struct packed {
      logic wake;
      logic remote;
      logic main_ok;
      logic backup_low;
      logic vin_high;
      logic vin_low;
      logic temp_high;
      logic temp_low;
      logic cap_full;
      logic alarm;
      logic out_in_range;
      logic out_cal_fail;
      logic out_calib_ok;
   } psl_cond_s;

endpackage

/* File: rtl/psl_status_led.sv */
/*
 * Supply status output, primary output sequencing and three status LEDs
 * (mirrored onto three off-board LEDs), with an AXI4-Lite register slave.
 * Assumes monitor inputs are asynchronous levels; aclk runs at 50 MHz.
 */
module psl_status_led
   import psl_pkg::*;
#(
   parameter int TENTH_CYC = CLK_HZ / 1000 * BLINK_PERIOD_MS / DUTY_SLOTS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic wake_input,
   input wire logic remote_in,
   input wire logic main_power_ok,
   input wire logic backup_low,
   input wire logic vin_high,
   input wire logic vin_low,
   input wire logic temp_high,
   input wire logic temp_low,
   input wire logic cap_full,
   input wire logic alarm,
   input wire logic out_in_range,
   input wire logic out_cal_fail,
   input wire logic out_calib_ok,
   output logic primary_output,
   output logic stat_o,
   output logic stat_oe,
   output logic hibernate_ok,
   output psl_rgb_t board_led_one,
   output psl_rgb_t board_led_two,
   output psl_rgb_t board_led_three,
   output psl_rgb_t offboard_led_four,
   output psl_rgb_t offboard_led_five,
   output psl_rgb_t offboard_led_six
);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************************************************************
   // Input synchroniser
   // ****************************************************************
   psl_cond_s raw;
   psl_cond_s sync1_r;
   psl_cond_s cond;

   assign raw = '{wake_input, remote_in, main_power_ok, backup_low,
      vin_high, vin_low, temp_high, temp_low, cap_full, alarm,
      out_in_range, out_cal_fail, out_calib_ok};

   // Two stages; the first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '0;
         cond <= '0;
      end else begin
         sync1_r <= raw;
         cond <= sync1_r;
      end
   end

   // ****************************************************************
   // Register file and AXI4-Lite slave
   // ****************************************************************
   logic [2:0] ctrl_r, ctrl_nxt;
   logic [31:0] delay_r, delay_nxt;
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, status_word;
   psl_state_e state_r, state_nxt;
   logic pending, remote_on_r, stat_hold_r;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Live state for software; synchronised monitors included to ease bring-up
   assign status_word = {13'h0, pending, stat_hold_r, remote_on_r,
      primary_output, state_r, 13'(cond)};

   // Address and data may arrive in either order; answer once both held
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      ctrl_nxt = ctrl_r;
      delay_nxt = delay_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (aw_held_r && w_held_r) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         case (awaddr_r)
            ADDR_CTRL: begin
               if (wstrb_r[0]) begin
                  ctrl_nxt = wdata_r[2:0];
               end
            end
            ADDR_DELAY: begin
               for (int b = 0; b < 4; b++) begin
                  if (wstrb_r[b]) begin
                     delay_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
                  end
               end
            end
            ADDR_STATUS: ;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CTRL: rdata_nxt = {29'h0, ctrl_r};
            ADDR_DELAY: rdata_nxt = delay_r;
            ADDR_STATUS: rdata_nxt = status_word;
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         ctrl_r <= CTRL_RESET;
         delay_r <= DELAY_RESET;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         ctrl_r <= ctrl_nxt;
         delay_r <= delay_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ****************************************************************
   // Blink timebase: ten slots per one-second period
   // ****************************************************************
   logic [31:0] tenth_cnt_r, tenth_cnt_nxt;
   logic [3:0] slot_r, slot_nxt;
   logic tenth_tick, sec_tick;

   assign tenth_tick = (tenth_cnt_r == 32'(TENTH_CYC - 1));
   assign sec_tick = tenth_tick && (slot_r == LAST_SLOT);

   // One shared divider keeps every LED in phase
   always_comb begin
      tenth_cnt_nxt = tenth_tick ? 32'h0 : tenth_cnt_r + 32'h1;
      slot_nxt = slot_r;
      if (tenth_tick) begin
         slot_nxt = (slot_r == LAST_SLOT) ? 4'h0 : slot_r + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tenth_cnt_r <= 32'h0;
         slot_r <= 4'h0;
      end else begin
         tenth_cnt_r <= tenth_cnt_nxt;
         slot_r <= slot_nxt;
      end
   end

   a_slot_wrap: assert property (sec_tick |=> slot_r == 4'h0)
      else $error("blink slot did not wrap at period end");

   // ****************************************************************
   // Remote input, shutdown pending and output sequencing
   // ****************************************************************
   logic rem_act, rem_prev_r, remote_on_nxt, stat_hold_nxt;
   logic [15:0] sec_left_r, sec_left_nxt;

   assign rem_act = cond.remote ^ ctrl_r[CTRL_ACT_LOW];
   assign pending = !cond.main_ok || ctrl_r[CTRL_HOST_SD] || !remote_on_r
      || cond.backup_low;
   assign primary_output = (state_r == ST_ON) || (state_r == ST_SHUTDOWN);
   // Open drain: only ever drives low
   assign stat_o = 1'b0;
   assign stat_oe = (state_r == ST_ON) && !pending
      && !stat_hold_r;
   // Wake held high keeps the controller awake
   assign hibernate_ok = (state_r == ST_OFF) && !cond.main_ok
      && !cond.wake;

   always_comb begin
      // Momentary contacts toggle on each press, maintained follow level
      remote_on_nxt = remote_on_r;
      if (ctrl_r[CTRL_MOMENTARY]) begin
         if (rem_act && !rem_prev_r) begin
            remote_on_nxt = !remote_on_r;
         end
      end else begin
         remote_on_nxt = rem_act;
      end
      state_nxt = state_r;
      sec_left_nxt = sec_left_r;
      stat_hold_nxt = stat_hold_r;
      if (pending) begin
         stat_hold_nxt = 1'b1;
      end
      case (state_r)
         ST_OFF: begin
            if (!pending) begin
               state_nxt = ST_STARTUP;
               sec_left_nxt = delay_r[15:0];
            end
         end
         ST_STARTUP: begin
            if (pending) begin
               state_nxt = ST_OFF;
            end else if (sec_left_r == 16'h0) begin
               state_nxt = ST_ON;
               stat_hold_nxt = 1'b0;
            end else if (sec_tick) begin
               sec_left_nxt = sec_left_r - 16'h1;
            end
         end
         ST_ON: begin
            if (pending) begin
               state_nxt = ST_SHUTDOWN;
               sec_left_nxt = delay_r[31:16];
            end
         end
         ST_SHUTDOWN: begin
            // Committed: a cleared cause does not cancel the power-down
            if (sec_left_r == 16'h0) begin
               state_nxt = ST_OFF;
            end else if (sec_tick) begin
               sec_left_nxt = sec_left_r - 16'h1;
            end
         end
         default: state_nxt = ST_OFF;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rem_prev_r <= 1'b0;
         remote_on_r <= 1'b0;
         state_r <= ST_OFF;
         sec_left_r <= 16'h0;
         stat_hold_r <= 1'b1;
      end else begin
         rem_prev_r <= rem_act;
         remote_on_r <= remote_on_nxt;
         state_r <= state_nxt;
         sec_left_r <= sec_left_nxt;
         stat_hold_r <= stat_hold_nxt;
      end
   end

   a_stat_on_only: assert property (stat_oe |-> primary_output
      && !pending && !stat_o)
      else $error("status pin driven while off or pending");
   a_stat_release: assert property ($rose(stat_oe)
      |-> $past(state_r) == ST_STARTUP)
      else $error("status pin reasserted before output came back on");
   a_main_loss: assert property ((!cond.main_ok && state_r == ST_ON)
      |=> state_r == ST_SHUTDOWN)
      else $error("main power loss did not start shutdown");
   a_wake_hold: assert property (cond.wake |-> !hibernate_ok)
      else $error("hibernate allowed while wake held");

   // ****************************************************************
   // LED colour selection, registered; off-board LEDs mirror on-board
   // ****************************************************************
   psl_rgb_t led_in_r, led_in_nxt, led_bd_r, led_bd_nxt;
   psl_rgb_t led_out_r, led_out_nxt, v_col, t_col, cap_col;
   logic first_slot;

   assign first_slot = (slot_r == 4'h0);
   assign board_led_one = led_in_r;
   assign board_led_two = led_bd_r;
   assign board_led_three = led_out_r;
   assign offboard_led_four = led_in_r;
   assign offboard_led_five = led_bd_r;
   assign offboard_led_six = led_out_r;

   // Slot 0 is the 10 percent phase, slots 1..9 the 90 percent phase
   always_comb begin
      cap_col = cond.cap_full ? RGB_GREEN : RGB_YELLOW;
      if (first_slot) begin
         led_bd_nxt = cap_col;
      end else begin
         led_bd_nxt = cond.alarm ? RGB_RED : RGB_OFF;
      end
      v_col = cond.vin_high ? RGB_RED : (cond.vin_low ? RGB_BLUE : RGB_OFF);
      t_col = cond.temp_high ? RGB_RED
         : (cond.temp_low ? RGB_BLUE : RGB_OFF);
      if (cond.vin_high && cond.temp_high) begin
         led_in_nxt = RGB_RED;
      end else if (v_col == RGB_OFF && t_col == RGB_OFF) begin
         led_in_nxt = RGB_GREEN;
      end else begin
         led_in_nxt = first_slot ? t_col : v_col;
      end
      // Delay patterns win over plain in-range status
      case (state_r)
         ST_STARTUP: led_out_nxt = first_slot ? RGB_GREEN
            : RGB_OFF;
         ST_SHUTDOWN, ST_ON: begin
            if (cond.out_in_range) begin
               if (state_r == ST_SHUTDOWN) begin
                  led_out_nxt = first_slot ? RGB_OFF
                     : RGB_GREEN;
               end else begin
                  led_out_nxt = RGB_GREEN;
               end
            end else if (cond.out_calib_ok && !cond.out_cal_fail) begin
               led_out_nxt = RGB_ORANGE;
            end else begin
               led_out_nxt = RGB_RED;
            end
         end
         default: led_out_nxt = RGB_OFF;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         led_in_r <= RGB_OFF;
         led_bd_r <= RGB_OFF;
         led_out_r <= RGB_OFF;
      end else begin
         // Only package colours reach the words, each field within 0x3F
         led_in_r <= led_in_nxt;
         led_bd_r <= led_bd_nxt;
         led_out_r <= led_out_nxt;
      end
   end

   a_board_alarm: assert property ((!first_slot && cond.alarm)
      |=> board_led_two == RGB_RED)
      else $error("alarm not shown red in long phase");
   a_board_quiet: assert property ((!first_slot && !cond.alarm)
      |=> board_led_two == RGB_OFF)
      else $error("board LED lit in dark phase without alarm");
   a_input_hot: assert property ((cond.vin_high && cond.temp_high)
      |=> board_led_one == RGB_RED)
      else $error("double high fault not steady red");
   a_out_startup: assert property ((state_r == ST_STARTUP && !first_slot)
      |=> board_led_three == RGB_OFF)
      else $error("start-up pattern lit outside short phase");
   a_out_dark: assert property ((state_r == ST_OFF)
      |=> board_led_three == RGB_OFF)
      else $error("output LED lit while output off");

endmodule // psl_status_led

/* File: bench/psl_host_model.sv */
/*
 * Far-side model: board monitors, switches, wake pulse and the pulled-up
 * status line. Assumes the bench sets wanted levels just after an edge.
 */
module psl_host_model
   import psl_pkg::*;
#(
   parameter int WAKE_CYC = 6
) (
   input wire logic aclk,
   input wire psl_cond_s want,
   input wire logic wake_req,
   input wire logic stat_o,
   input wire logic stat_oe,
   output psl_cond_s cond,
   output logic stat_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int wake_cnt = 0;

   // Open drain with an external pull-up: a released line reads high
   assign stat_pin = stat_oe ? stat_o : 1'b1;

   // Wake is only ever a short pulse, so hibernation is blocked for WAKE_CYC cycles
   always_ff @(posedge aclk) begin
      if (wake_req) begin
         wake_cnt <= WAKE_CYC;
      end else if (wake_cnt > 0) begin
         wake_cnt <= wake_cnt - 1;
      end
   end

   // Monitor levels pass through, wake comes from the pulse counter
   always_comb begin
      cond = want;
      cond.wake = (wake_cnt > 0);
   end
endmodule // psl_host_model

/* File: bench/test_power_status_led_indicator.sv */
/*
 * Self-checking bench: AXI4-Lite access tasks, LED colour counts over
 * whole blink periods, status pin and sequencing checks.
 * Assumes a shortened tenth count so one period is 40 clocks.
 */
module test_power_status_led_indicator
   import psl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TENTH = 4;
   localparam int PER = 10 * TENTH;
   localparam int WAKE = 6;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, primary_output, stat_o, stat_oe, hibernate_ok;
   logic stat_pin, b0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, d;
   psl_rgb_t board_led_one, board_led_two, board_led_three;
   psl_rgb_t offboard_led_four, offboard_led_five, offboard_led_six;
   psl_cond_s want = '0;
   psl_cond_s cond;
   logic wake_req = 1'b0;
   int err_count = 0;
   int checks_done = 0;
   // Input faults: vin_high vin_low temp_high temp_low, colours, counts
   logic [3:0] ftab [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hA, 4'h6};
   psl_rgb_t atab [6] = '{RGB_RED, RGB_BLUE, RGB_OFF, RGB_OFF, RGB_RED,
      RGB_BLUE};
   psl_rgb_t btab [6] = '{RGB_OFF, RGB_OFF, RGB_RED, RGB_BLUE, RGB_RED,
      RGB_RED};
   int ntab [6] = '{36, 36, 36, 36, 40, 36};
   int mtab [6] = '{4, 4, 4, 4, 40, 4};

   psl_status_led #(.TENTH_CYC(TENTH)) u_psl_status_led (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .wake_input(cond.wake),
      .remote_in(cond.remote), .main_power_ok(cond.main_ok),
      .backup_low(cond.backup_low), .vin_high(cond.vin_high),
      .vin_low(cond.vin_low), .temp_high(cond.temp_high),
      .temp_low(cond.temp_low), .cap_full(cond.cap_full),
      .alarm(cond.alarm), .out_in_range(cond.out_in_range),
      .out_cal_fail(cond.out_cal_fail), .out_calib_ok(cond.out_calib_ok),
      .primary_output, .stat_o, .stat_oe, .hibernate_ok, .board_led_one,
      .board_led_two, .board_led_three, .offboard_led_four,
      .offboard_led_five, .offboard_led_six);

   psl_host_model #(.WAKE_CYC(WAKE)) u_psl_host_model (.aclk, .want,
      .wake_req, .stat_o, .stat_oe, .cond, .stat_pin);

   // ****************************************************************
   // Tasks
   // ****************************************************************
   // One comparison, counted, reported at once on a mismatch
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Starts after an edge so no signal is assigned twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er,
      output logic [31:0] v);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      chk("rresp", s_axi_rresp, er);
   endtask

   // Counts over a whole period, so the result is free of slot phase
   task automatic meas(input int k, input psl_rgb_t a, input int na,
      input psl_rgb_t b, input int nb);
      int ca, cb, mm, bad;
      psl_rgb_t w, m;
      ca = 0;
      cb = 0;
      mm = 0;
      bad = 0;
      repeat (PER) begin
         @(posedge aclk);
         w = k == 0 ? board_led_one : k == 1 ? board_led_two :
            board_led_three;
         m = k == 0 ? offboard_led_four : k == 1 ? offboard_led_five :
            offboard_led_six;
         ca += (w === a);
         cb += (w === b);
         mm += (w !== m);
         bad += ((w & 32'hFFC0_C0C0) !== 32'h0000_0000);
      end
      chk("colour a cycles", 32'(ca), 32'(na));
      chk("colour b cycles", 32'(cb), 32'(nb));
      chk("mirror led", 32'(mm), 32'h0);
      chk("colour code", 32'(bad), 32'h0);
   endtask

   task automatic wait_po(input logic v);
      int n;
      n = 0;
      while (primary_output !== v && n < 400) begin
         @(posedge aclk);
         n++;
      end
      chk("primary_output", primary_output, v);
   endtask

   // Applies or removes one of the shutdown causes
   task automatic cause(input int k, input logic on);
      case (k)
         0: want.main_ok <= !on;
         1: wr(ADDR_CTRL, {31'h0, on}, RESP_OKAY);
         2: want.remote <= !on;
         default: want.backup_low <= on;
      endcase
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ****************************************************************
   // Clock, watchdog and test sequence
   // ****************************************************************
   initial begin
      forever #10 aclk = ~aclk;
   end

   // Whole run is a few thousand clocks; this leaves wide margin
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_CTRL, RESP_OKAY, d);
      chk("ctrl reset", d, 32'(CTRL_RESET));
      rd(ADDR_DELAY, RESP_OKAY, d);
      chk("delay reset", d, DELAY_RESET);
      rd(8'h0C, RESP_SLVERR, d);
      chk("bad read data", d, 32'h0000_0000);
      wr(8'h0C, 32'hFFFF_FFFF, RESP_SLVERR);
      $display("register map test done");
      want.main_ok <= 1'b1;
      want.remote <= 1'b1;
      want.cap_full <= 1'b1;
      want.out_in_range <= 1'b1;
      wait_po(1'b1);
      tick(4);
      chk("stat on", stat_pin, 1'b0);
      meas(2, RGB_GREEN, PER, RGB_GREEN, PER);
      meas(0, RGB_GREEN, PER, RGB_GREEN, PER);
      meas(1, RGB_GREEN, TENTH, RGB_OFF, PER - TENTH);
      want.cap_full <= 1'b0;
      tick(5);
      meas(1, RGB_YELLOW, TENTH, RGB_OFF, PER - TENTH);
      want.cap_full <= 1'b1;
      want.alarm <= 1'b1;
      tick(5);
      meas(1, RGB_GREEN, TENTH, RGB_RED, PER - TENTH);
      want.alarm <= 1'b0;
      want.out_in_range <= 1'b0;
      want.out_cal_fail <= 1'b1;
      tick(5);
      meas(2, RGB_RED, PER, RGB_RED, PER);
      want.out_cal_fail <= 1'b0;
      want.out_calib_ok <= 1'b1;
      tick(5);
      meas(2, RGB_ORANGE, PER, RGB_ORANGE, PER);
      want.out_in_range <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         {want.vin_high, want.vin_low, want.temp_high, want.temp_low} <=
            ftab[i];
         tick(5);
         meas(0, atab[i], ntab[i],
            btab[i], mtab[i]);
      end
      {want.vin_high, want.vin_low, want.temp_high, want.temp_low} <= 4'h0;
      $display("led pattern test done");
      wr(ADDR_DELAY, 32'h0003_0003, RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
         cause(k, 1'b1);
         tick(6);
         chk("stat pending", stat_pin, 1'b1);
         if (k == 0) begin
            meas(2, RGB_GREEN, PER - TENTH,
               RGB_OFF, TENTH);
         end
         wait_po(1'b0);
         if (k == 0) begin
            meas(2, RGB_OFF, PER, RGB_OFF, PER);
         end
         cause(k, 1'b0);
         tick(6);
         chk("stat startup", stat_pin, 1'b1);
         if (k == 0) begin
            meas(2, RGB_GREEN, TENTH,
               RGB_OFF, PER - TENTH);
         end
         wait_po(1'b1);
         tick(4);
         chk("stat back on", stat_pin, 1'b0);
      end
      $display("shutdown cause test done");
      cause(0, 1'b1);
      wait_po(1'b0);
      tick(4);
      chk("hibernate idle", hibernate_ok, 1'b1);
      wake_req <= 1'b1;
      tick(1);
      wake_req <= 1'b0;
      tick(4);
      chk("hibernate wake", hibernate_ok, 1'b0);
      tick(WAKE + 4);
      chk("hibernate after", hibernate_ok, 1'b1);
      cause(0, 1'b0);
      wait_po(1'b1);
      $display("wake test done");
      wr(ADDR_CTRL, 32'h0000_0004, RESP_OKAY);
      tick(5);
      rd(ADDR_STATUS, RESP_OKAY, d);
      chk("remote low idle", d[16], 1'b0);
      want.remote <= 1'b0;
      tick(5);
      rd(ADDR_STATUS, RESP_OKAY, d);
      chk("remote low on", d[16], 1'b1);
      wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
      tick(5);
      rd(ADDR_STATUS, RESP_OKAY, d);
      b0 = d[16];
      want.remote <= 1'b1;
      tick(5);
      want.remote <= 1'b0;
      tick(5);
      rd(ADDR_STATUS, RESP_OKAY, d);
      chk("remote toggle", d[16], !b0);
      $display("remote input test done");
      end_of_test();
   end
endmodule // test_power_status_led_indicator
